// file: design/peripheral_pin_select.sv
// Purpose: remappable pin selection, input routing and output function assignment
// Assumes: apb slave with zero wait states; pins arrive from outside the clock domain
// Notes: selected peripheral inputs and output pins come from flip-flops
`timescale 1ns/10ps
`include "pin_select_consts.svh"
module peripheral_pin_select #(
  parameter int PIN_COUNT = 128,
  parameter int FUNCTION_COUNT = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pin_select_pkg::reg_addr_t paddr,
  input wire pin_select_pkg::bus_word_t pwdata,
  input wire logic [3:0] pstrb,
  output pin_select_pkg::bus_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_COUNT-1:0] remap_pins_in,
  input wire logic first_comparator_output,
  input wire logic [FUNCTION_COUNT-1:0] function_outputs,
  output logic capture1_in,
  output logic capture2_in,
  output logic fault_a_in,
  output logic fault_b_in,
  output logic codec_frame_sync_in,
  output logic pin70_out,
  output logic pin70_oe,
  output logic pin71_out,
  output logic pin71_oe,
  output logic pin79_out,
  output logic pin79_oe,
  output logic pin80_out,
  output logic pin80_oe
);
  import pin_select_pkg::*;

  // ****************************************
  // selector registers
  // ****************************************
  input_code_t capture1_source;
  input_code_t capture2_source;
  input_code_t fault_a_source;
  input_code_t fault_b_source;
  input_code_t frame_sync_source;
  function_code_t pin70_function_code;
  function_code_t pin71_function_code;
  function_code_t pin79_function_code;
  function_code_t pin80_function_code;

  logic write_access;
  logic read_access;
  logic addr_mapped;
  logic lane0_write;
  logic lane1_write;
  bus_word_t next_prdata;

  // ****************************************
  // apb decode
  // ****************************************
  // zero wait states: every access completes at its first access-phase edge
  assign pready = 1'b1;
  assign write_access = psel && penable && pwrite;
  assign read_access = psel && penable && !pwrite;
  assign lane0_write = write_access && pstrb[0];
  assign lane1_write = write_access && pstrb[1];

  always_comb begin
    if (paddr == `OFS_CAPTURE_INPUT_SELECT) begin
      addr_mapped = 1'b1;
    end else if (paddr == `OFS_COMPARE_FAULT_INPUT_SELECT) begin
      addr_mapped = 1'b1;
    end else if (paddr == `OFS_FRAME_SYNC_INPUT_SELECT) begin
      addr_mapped = 1'b1;
    end else if (paddr == `OFS_OUTPUT_SELECT_PINS_70_71) begin
      addr_mapped = 1'b1;
    end else if (paddr == `OFS_OUTPUT_SELECT_PINS_79_80) begin
      addr_mapped = 1'b1;
    end else if (paddr == `OFS_ROUTING_STATUS) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  end

  // unmapped addresses answer with an error and change nothing
  assign pslverr = psel && penable && !addr_mapped;

  // ****************************************
  // selector writes
  // ****************************************
  // only the field bits are stored, so unused positions cannot be set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture1_source <= `RST_INPUT_CODE;
      capture2_source <= `RST_INPUT_CODE;
    end else if (paddr == `OFS_CAPTURE_INPUT_SELECT) begin
      if (lane0_write) begin
        capture1_source <= pwdata[`POS_LOW_INPUT_FIELD +: 7];
      end
      if (lane1_write) begin
        capture2_source <= pwdata[`POS_HIGH_INPUT_FIELD +: 7];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_a_source <= `RST_INPUT_CODE;
      fault_b_source <= `RST_INPUT_CODE;
    end else if (paddr == `OFS_COMPARE_FAULT_INPUT_SELECT) begin
      if (lane0_write) begin
        fault_a_source <= pwdata[`POS_LOW_INPUT_FIELD +: 7];
      end
      if (lane1_write) begin
        fault_b_source <= pwdata[`POS_HIGH_INPUT_FIELD +: 7];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_source <= `RST_INPUT_CODE;
    end else if (paddr == `OFS_FRAME_SYNC_INPUT_SELECT && lane0_write) begin
      frame_sync_source <= pwdata[`POS_LOW_INPUT_FIELD +: 7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin70_function_code <= `RST_FUNCTION_CODE;
      pin71_function_code <= `RST_FUNCTION_CODE;
    end else if (paddr == `OFS_OUTPUT_SELECT_PINS_70_71) begin
      if (lane0_write) begin
        pin70_function_code <= pwdata[`POS_LOW_OUTPUT_FIELD +: 6];
      end
      if (lane1_write) begin
        pin71_function_code <= pwdata[`POS_HIGH_OUTPUT_FIELD +: 6];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin79_function_code <= `RST_FUNCTION_CODE;
      pin80_function_code <= `RST_FUNCTION_CODE;
    end else if (paddr == `OFS_OUTPUT_SELECT_PINS_79_80) begin
      if (lane0_write) begin
        pin79_function_code <= pwdata[`POS_LOW_OUTPUT_FIELD +: 6];
      end
      if (lane1_write) begin
        pin80_function_code <= pwdata[`POS_HIGH_OUTPUT_FIELD +: 6];
      end
    end
  end

  // ****************************************
  // pin input synchronisers
  // ****************************************
  // three stages; a level is accepted only once stages two and three agree,
  // which costs one cycle of latency but rejects single-cycle glitches
  logic [PIN_COUNT-1:0] pin_stage1;
  logic [PIN_COUNT-1:0] pin_stage2;
  logic [PIN_COUNT-1:0] pin_stage3;
  logic [PIN_COUNT-1:0] pin_level;
  logic cmp_stage1;
  logic cmp_stage2;
  logic cmp_stage3;
  logic cmp_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_stage1 <= '0;
      pin_stage2 <= '0;
      pin_stage3 <= '0;
    end else begin
      pin_stage1 <= remap_pins_in;
      pin_stage2 <= pin_stage1;
      pin_stage3 <= pin_stage2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= '0;
    end else begin
      pin_level <= (pin_stage2 & pin_stage3) | (pin_level & (pin_stage2 ^ pin_stage3));
    end
  end

  // the comparator output is asynchronous to pclk as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_stage1 <= 1'b0;
      cmp_stage2 <= 1'b0;
      cmp_stage3 <= 1'b0;
      cmp_level <= 1'b0;
    end else begin
      cmp_stage1 <= first_comparator_output;
      cmp_stage2 <= cmp_stage1;
      cmp_stage3 <= cmp_stage2;
      if (cmp_stage2 == cmp_stage3) begin
        cmp_level <= cmp_stage3;
      end
    end
  end

  // ****************************************
  // input routing
  // ****************************************
  // code 0 is ground, code 1 the comparator, any other code the pin of that number,
  // so pins 0 and 1 can never be selected
  logic [PIN_COUNT-1:0] input_sources;
  assign input_sources = {pin_level[PIN_COUNT-1:2], cmp_level, 1'b0};

  select_mux #(.SEL_W(7), .N(PIN_COUNT)) capture1_mux (.pclk(pclk), .presetn(presetn),
    .sources(input_sources), .code(capture1_source), .selected(capture1_in));

  select_mux #(.SEL_W(7), .N(PIN_COUNT)) capture2_mux (.pclk(pclk), .presetn(presetn),
    .sources(input_sources), .code(capture2_source), .selected(capture2_in));

  select_mux #(.SEL_W(7), .N(PIN_COUNT)) fault_a_mux (.pclk(pclk), .presetn(presetn),
    .sources(input_sources), .code(fault_a_source), .selected(fault_a_in));

  select_mux #(.SEL_W(7), .N(PIN_COUNT)) fault_b_mux (.pclk(pclk), .presetn(presetn),
    .sources(input_sources), .code(fault_b_source), .selected(fault_b_in));

  select_mux #(.SEL_W(7), .N(PIN_COUNT)) frame_sync_mux (.pclk(pclk), .presetn(presetn),
    .sources(input_sources), .code(frame_sync_source), .selected(codec_frame_sync_in));

  // ****************************************
  // output function assignment
  // ****************************************
  // function code 0 means no peripheral owns the pin: it reads low and is released
  logic [FUNCTION_COUNT-1:0] function_sources;
  assign function_sources = {function_outputs[FUNCTION_COUNT-1:1], 1'b0};

  select_mux #(.SEL_W(6), .N(FUNCTION_COUNT)) pin70_mux (.pclk(pclk), .presetn(presetn),
    .sources(function_sources), .code(pin70_function_code), .selected(pin70_out));

  select_mux #(.SEL_W(6), .N(FUNCTION_COUNT)) pin71_mux (.pclk(pclk), .presetn(presetn),
    .sources(function_sources), .code(pin71_function_code), .selected(pin71_out));

  select_mux #(.SEL_W(6), .N(FUNCTION_COUNT)) pin79_mux (.pclk(pclk), .presetn(presetn),
    .sources(function_sources), .code(pin79_function_code), .selected(pin79_out));

  select_mux #(.SEL_W(6), .N(FUNCTION_COUNT)) pin80_mux (.pclk(pclk), .presetn(presetn),
    .sources(function_sources), .code(pin80_function_code), .selected(pin80_out));

  // enables are registered beside the data so both change on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin70_oe <= 1'b0;
      pin71_oe <= 1'b0;
      pin79_oe <= 1'b0;
      pin80_oe <= 1'b0;
    end else begin
      pin70_oe <= pin70_function_code != `CODE_NO_FUNCTION;
      pin71_oe <= pin71_function_code != `CODE_NO_FUNCTION;
      pin79_oe <= pin79_function_code != `CODE_NO_FUNCTION;
      pin80_oe <= pin80_function_code != `CODE_NO_FUNCTION;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    next_prdata = '0;
    if (paddr == `OFS_CAPTURE_INPUT_SELECT) begin
      next_prdata[`POS_LOW_INPUT_FIELD +: 7] = capture1_source;
      next_prdata[`POS_HIGH_INPUT_FIELD +: 7] = capture2_source;
    end else if (paddr == `OFS_COMPARE_FAULT_INPUT_SELECT) begin
      next_prdata[`POS_LOW_INPUT_FIELD +: 7] = fault_a_source;
      next_prdata[`POS_HIGH_INPUT_FIELD +: 7] = fault_b_source;
    end else if (paddr == `OFS_FRAME_SYNC_INPUT_SELECT) begin
      next_prdata[`POS_LOW_INPUT_FIELD +: 7] = frame_sync_source;
    end else if (paddr == `OFS_OUTPUT_SELECT_PINS_70_71) begin
      next_prdata[`POS_LOW_OUTPUT_FIELD +: 6] = pin70_function_code;
      next_prdata[`POS_HIGH_OUTPUT_FIELD +: 6] = pin71_function_code;
    end else if (paddr == `OFS_OUTPUT_SELECT_PINS_79_80) begin
      next_prdata[`POS_LOW_OUTPUT_FIELD +: 6] = pin79_function_code;
      next_prdata[`POS_HIGH_OUTPUT_FIELD +: 6] = pin80_function_code;
    end else if (paddr == `OFS_ROUTING_STATUS) begin
      next_prdata[`POS_STATUS_INPUTS +: 5] =
        {codec_frame_sync_in, fault_b_in, fault_a_in, capture2_in, capture1_in};
      next_prdata[`POS_STATUS_LEVELS +: 4] = {pin80_out, pin79_out, pin71_out, pin70_out};
      next_prdata[`POS_STATUS_ENABLES +: 4] = {pin80_oe, pin79_oe, pin71_oe, pin70_oe};
    end
  end

  // read data is captured in the setup phase so it is a flop during the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end else if (read_access) begin
      prdata <= '0;
    end
  end

endmodule : peripheral_pin_select

// file: design/pin_select_consts.svh
// Purpose: offsets, field positions, reset values and codes of the pin select block
// Assumes: byte addresses on a 32-bit apb bus, one aligned word per register
// Notes: definitions only
`ifndef PIN_SELECT_CONSTS_SVH
`define PIN_SELECT_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CAPTURE_INPUT_SELECT 12'h000
`define OFS_COMPARE_FAULT_INPUT_SELECT 12'h004
`define OFS_FRAME_SYNC_INPUT_SELECT 12'h008
`define OFS_OUTPUT_SELECT_PINS_70_71 12'h00c
`define OFS_OUTPUT_SELECT_PINS_79_80 12'h010
`define OFS_ROUTING_STATUS 12'h014

// ****************************************
// field positions (low bit of each field)
// ****************************************
`define POS_LOW_INPUT_FIELD 0
`define POS_HIGH_INPUT_FIELD 8
`define POS_LOW_OUTPUT_FIELD 0
`define POS_HIGH_OUTPUT_FIELD 8
`define POS_STATUS_INPUTS 0
`define POS_STATUS_LEVELS 8
`define POS_STATUS_ENABLES 12

// ****************************************
// reset values and fixed codes
// ****************************************
`define RST_INPUT_CODE 7'h00
`define RST_FUNCTION_CODE 6'h00
`define CODE_GROUND 7'h00
`define CODE_FIRST_COMPARATOR 7'h01
`define CODE_NO_FUNCTION 6'h00

`endif

// file: design/pin_select_pkg.sv
// Purpose: shared types of the pin select block
// Assumes: seven-bit input codes, six-bit output function codes
// Notes: numbers live in pin_select_consts.svh
package pin_select_pkg;

  typedef logic [6:0] input_code_t;
  typedef logic [5:0] function_code_t;
  typedef logic [11:0] reg_addr_t;
  typedef logic [31:0] bus_word_t;

endpackage : pin_select_pkg

// file: design/select_mux.sv
// Purpose: registered selector, picks one of n sources by a binary code
// Assumes: sources and code are on the same clock as the register
// Notes: codes beyond the source count read as low
`timescale 1ns/10ps
module select_mux #(
  parameter int SEL_W = 7,
  parameter int N = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] sources,
  input wire logic [SEL_W-1:0] code,
  output logic selected
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected <= 1'b0;
    end else if (int'(code) < N) begin
      selected <= sources[code];
    end else begin
      selected <= 1'b0;
    end
  end

endmodule : select_mux

// file: test/pin_select_checker.sv
// Purpose: bus and routing properties of the pin select block
// Assumes: zero wait state apb, registered routing outputs
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
`include "pin_select_consts.svh"
module pin_select_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pin_select_pkg::reg_addr_t paddr,
  input wire pin_select_pkg::bus_word_t pwdata,
  input wire logic [3:0] pstrb,
  input wire pin_select_pkg::bus_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture1_in,
  input wire logic pin70_out,
  input wire logic pin70_oe,
  input wire logic pin71_oe
);
  import pin_select_pkg::*;
  logic acc;
  logic rd;
  logic wr;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign wr = acc && pwrite;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************
  // properties
  // ****************************************
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr[1:0] == 2'b00 && paddr > `OFS_ROUTING_STATUS
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= `OFS_ROUTING_STATUS && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped access refused");
  a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_frame_unused: assert property (rd && paddr == `OFS_FRAME_SYNC_INPUT_SELECT
    |-> prdata[15:7] == 9'h000) else $error("frame sync unused bits set");
  a_input_unused: assert property (rd && paddr <= `OFS_COMPARE_FAULT_INPUT_SELECT
    |-> !prdata[15] && !prdata[7]) else $error("input select unused bits set");
  a_out_unused: assert property (rd && paddr == `OFS_OUTPUT_SELECT_PINS_70_71
    |-> prdata[15:14] == 2'b00 && prdata[7:6] == 2'b00) else $error("output unused bits set");
  a_pin70_oe: assert property (wr && pstrb[0] && paddr == `OFS_OUTPUT_SELECT_PINS_70_71
    |-> ##2 pin70_oe == ($past(pwdata[5:0], 2) != 6'h00)) else $error("pin70 enable wrong");
  a_pin71_oe: assert property (wr && pstrb[1] && paddr == `OFS_OUTPUT_SELECT_PINS_70_71
    |-> ##2 pin71_oe == ($past(pwdata[13:8], 2) != 6'h00)) else $error("pin71 enable wrong");
  a_pin70_idle: assert property (!pin70_oe |-> !pin70_out)
    else $error("pin70 driven while off");
  a_ground_low: assert property (wr && pstrb[0] && paddr == `OFS_CAPTURE_INPUT_SELECT
    && pwdata[6:0] == 7'h00 |-> ##2 !capture1_in) else $error("ground select not low");
  c_unmapped: cover property (acc && pslverr);
  c_pin_on: cover property ($rose(pin71_oe));
  c_frame_read: cover property (rd && paddr == `OFS_FRAME_SYNC_INPUT_SELECT);
endmodule : pin_select_checker

bind peripheral_pin_select pin_select_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .capture1_in, .pin70_out, .pin70_oe,
  .pin71_oe);

// file: test/peripheral_pin_select_tb.sv
// Purpose: self-checking bench of the pin select block
// Assumes: zero wait state apb, routed inputs settle within 8 cycles
// Notes: model keeps register words as ints with field masks
`timescale 1ns/10ps
`include "pin_select_consts.svh"
module peripheral_pin_select_tb;
  import pin_select_pkg::*;
  `define CHK(nm, ex, got) begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
  logic pclk;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg_addr_t paddr = '0;
  bus_word_t pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [127:0] remap_pins_in = '0;
  logic first_comparator_output = 1'b0;
  logic [63:0] function_outputs = '0;
  bus_word_t prdata;
  logic pready, pslverr, capture1_in, capture2_in, fault_a_in, fault_b_in, codec_frame_sync_in;
  logic pin70_out, pin70_oe, pin71_out, pin71_oe, pin79_out, pin79_oe, pin80_out, pin80_oe;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'hfe39b989;
  int mdl[0:6] = '{default: 0};
  int msk[0:6] = '{'h7f7f, 'h7f7f, 'h7f, 'h3f3f, 'h3f3f, 0, 0};
  int codes[6] = '{0, 1, 2, 64, 126, 127};

  peripheral_pin_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .remap_pins_in, .first_comparator_output,
    .function_outputs, .capture1_in, .capture2_in, .fault_a_in, .fault_b_in,
    .codec_frame_sync_in, .pin70_out, .pin70_oe, .pin71_out, .pin71_oe, .pin79_out,
    .pin79_oe, .pin80_out, .pin80_oe);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic src(input int c, input logic [127:0] pv, input logic cm);
    return c == 0 ? 1'b0 : (c == 1 ? cm : pv[c]);
  endfunction : src

  function automatic logic [1:0] fo(input int c, input logic [63:0] fv);
    return c == 0 ? 2'b00 : {1'b1, fv[c]};
  endfunction : fo

  task automatic apb(input logic w, input int a, input bus_word_t d, input logic [3:0] s,
                     output bus_word_t rd, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= reg_addr_t'(a);
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int a, input bus_word_t d, input logic [3:0] s);
    bus_word_t rd;
    logic e;
    int lm;
    lm = (s[0] ? 'hff : 0) | (s[1] ? 'hff00 : 0);
    apb(1'b1, a, d, s, rd, e);
    mdl[a / 4] = (mdl[a / 4] & ~lm) | (int'(d) & lm & msk[a / 4]);
    `CHK("write err", a > 20, e)
  endtask : wr

  task automatic rdc(input int a);
    bus_word_t rd;
    logic e;
    apb(1'b0, a, rnd(), 4'h0, rd, e);
    `CHK("prdata", bus_word_t'(mdl[a / 4]), rd)
    `CHK("read err", a > 20, e)
  endtask : rdc

  task automatic route_chk();
    logic [127:0] pv;
    logic [63:0] fv;
    logic cm;
    logic [4:0] ei;
    logic [7:0] eo;
    logic [15:0] es;
    bus_word_t rd;
    logic e;
    pv = {rnd(), rnd(), rnd(), rnd()};
    fv = {rnd(), rnd()};
    cm = 1'(rnd());
    @(posedge pclk);
    remap_pins_in <= pv;
    first_comparator_output <= cm;
    function_outputs <= fv;
    // pins pass a three stage filter, so allow the full settle time
    repeat (8) @(posedge pclk);
    `CHK("capture1", src(mdl[0] & 127, pv, cm), capture1_in)
    `CHK("capture2", src(mdl[0] >> 8 & 127, pv, cm), capture2_in)
    `CHK("fault_a", src(mdl[1] & 127, pv, cm), fault_a_in)
    `CHK("fault_b", src(mdl[1] >> 8 & 127, pv, cm), fault_b_in)
    `CHK("frame_sync", src(mdl[2] & 127, pv, cm), codec_frame_sync_in)
    `CHK("pin70", fo(mdl[3] & 63, fv), {pin70_oe, pin70_out})
    `CHK("pin71", fo(mdl[3] >> 8 & 63, fv), {pin71_oe, pin71_out})
    `CHK("pin79", fo(mdl[4] & 63, fv), {pin79_oe, pin79_out})
    `CHK("pin80", fo(mdl[4] >> 8 & 63, fv), {pin80_oe, pin80_out})
    ei = {src(mdl[2] & 127, pv, cm), src(mdl[1] >> 8 & 127, pv, cm),
      src(mdl[1] & 127, pv, cm), src(mdl[0] >> 8 & 127, pv, cm), src(mdl[0] & 127, pv, cm)};
    eo = {fo(mdl[4] >> 8 & 63, fv), fo(mdl[4] & 63, fv), fo(mdl[3] >> 8 & 63, fv),
      fo(mdl[3] & 63, fv)};
    es = {eo[7], eo[5], eo[3], eo[1], eo[6], eo[4], eo[2], eo[0], 3'b000, ei};
    // routed outputs stand still during this read, so the status word must mirror them
    apb(1'b0, 20, rnd(), 4'h0, rd, e);
    `CHK("status", bus_word_t'(es), rd)
    `CHK("status err", 1'b0, e)
  endtask : route_chk

  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    close_out();
  end

  initial begin
    int a;
    bus_word_t d;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i <= 24; i += 4) rdc(i);
    route_chk();
    for (int i = 0; i < 30; i++) begin
      a = (rnd() % 6) * 4;
      // status word is skipped: its value follows pins, not the model
      if (a == 20) a = 24;
      if (rnd() % 2) wr(a, rnd(), 4'(rnd()));
      else rdc(a);
    end
    foreach (codes[i]) begin
      d = rnd();
      d[6:0] = codes[i][6:0];
      wr(0, d, 4'hf);
      d[14:8] = codes[i][6:0];
      wr(4, d, 4'hf);
      wr(8, d, 4'hf);
      d[5:0] = codes[i][5:0];
      d[13:8] = codes[5 - i][5:0];
      wr(12, d, 4'hf);
      wr(16, rnd(), 4'hf);
      route_chk();
      rdc(12);
    end
    // a reset in mid-run must bring every selector back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mdl = '{default: 0};
    for (int i = 0; i <= 24; i += 4) rdc(i);
    route_chk();
    close_out();
  end
endmodule : peripheral_pin_select_tb
